// ==== rtl/plk_pkg.sv ====
package plk_pkg;

    // Oscillator mode selection, as configured
    typedef enum logic [2:0] {
        PLK_MODE_EC     = 3'h0,  // external_clock_input_mode
        PLK_MODE_EC_PLL = 3'h1,  // external clock through the 4x loop
        PLK_MODE_XT     = 3'h2,  // medium_gain_crystal_mode
        PLK_MODE_XT_PLL = 3'h3,
        PLK_MODE_HS     = 3'h4,  // high_gain_crystal_mode
        PLK_MODE_FRC    = 3'h5,  // internal_fast_rc_source
        PLK_MODE_FRC_PLL = 3'h6,
        PLK_MODE_OTHER  = 3'h7
    } plk_mode_e;

    // PLL branch states, Gray along idle -> settle -> locked
    typedef enum logic [1:0] {
        PLK_ST_IDLE   = 2'h0,
        PLK_ST_SETTLE = 2'h1,
        PLK_ST_LOCKED = 2'h3
    } plk_state_e;

    // Pin group for the second oscillator pin
    typedef struct packed {
        logic out;   // Level driven onto the pin
        logic oe;    // High while the device drives the pin
    } plk_pin_s;

    localparam int unsigned PLK_MULT          = 4;
    localparam int unsigned PLK_SETTLE_W      = 12;
    localparam logic [11:0] PLK_SETTLE_CYCLES = 12'h200;
    localparam int unsigned PLK_LOCK_BIT      = 5;
    localparam int unsigned PLK_CTRL_W        = 16;
    localparam logic [15:0] PLK_CTRL_RST      = 16'h0000;
    localparam logic [11:0] PLK_CNT_ONE       = 12'h001;
    localparam logic [11:0] PLK_CNT_ZERO      = 12'h000;

endpackage

// ==== rtl/plk_clock_path.sv ====
`timescale 1ns/1ps
`default_nettype none

module plk_clock_path
    import plk_pkg::*;
(
    input  wire logic                  core_clk,          // System clock, 20 MHz
    input  wire logic                  rst,               // Synchronous reset, active high
    input  wire logic [2:0]            osc_mode,          // Selected oscillator mode
    input  wire logic                  osc_pin_clkout_select, // Clock-out config bit
    input  wire logic                  ref_tick,          // Reference clock pin, asynchronous
    input  wire logic                  gpio_out,          // Port value for the pin
    input  wire logic                  gpio_oe,           // Port enable for the pin
    input  wire logic [PLK_CTRL_W-1:0] ctrl_wdata,        // Software value for control reg
    input  wire logic                  ctrl_we,           // Write strobe for control reg
    output logic [PLK_CTRL_W-1:0]      oscillator_control_reg, // Control reg read value
    output plk_pin_s                   osc_output_pin,    // Second oscillator pin drive
    output logic                       feedback_en,       // Feedback stage enable
    output logic                       pll_enable,        // PLL branch powered
    output logic [2:0]                 pll_mult_m1,       // Multiplier minus one
    output logic                       pll_ready,         // PLL output usable
    output logic                       pll_lock           // Lock status
);

    plk_mode_e                mode;
    logic                     ref_s1_r;
    logic                     ref_s2_r;
    logic                     ref_s3_r;
    logic                     ref_edge;
    logic                     div_r, div_nxt;
    plk_pin_s                 pin_r, pin_nxt;
    logic                     fb_r, fb_nxt;
    logic                     pen_r, pen_nxt;
    logic [2:0]               mult_r, mult_nxt;
    plk_state_e               st_r, st_nxt;
    logic [PLK_SETTLE_W-1:0]  cnt_r, cnt_nxt;
    plk_mode_e                src_r, src_nxt;
    logic                     lock_r, lock_nxt;
    logic [PLK_CTRL_W-1:0]    ctrl_r, ctrl_nxt;
    logic                     uses_pll;
    logic                     src_changed;

    // Mode decode and reference edge pick-up.
    // Every code of the mode field is a named mode, so the cast cannot
    // produce a value outside the enum; the spare code acts as a plain source.
    // A source change is seen against the mode registered one edge earlier.
    assign mode        = plk_mode_e'(osc_mode);
    assign uses_pll    = (mode == PLK_MODE_EC_PLL) || (mode == PLK_MODE_XT_PLL)
                      || (mode == PLK_MODE_FRC_PLL);
    assign src_changed = (mode != src_r);
    assign ref_edge    = ref_s2_r & ~ref_s3_r;

    // Reference clock synchroniser and edge stage.
    // The pin is asynchronous: only the second stage is read, by the third
    // stage and the edge detect. All stages reset low, the idle level of a
    // stopped source, so no false edge follows reset.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ref_s1_r <= 1'b0;
            ref_s2_r <= 1'b0;
            ref_s3_r <= 1'b0;
        end
        else
        begin
            ref_s1_r <= ref_tick;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
        end
    end

    // Pin, feedback and multiplier next values.
    // The divider runs in every mode so the half-rate pin clock never
    // starts with a short first phase when clock-out is chosen.
    // Crystal modes keep the feedback stage on and leave the pin to the
    // resonator; the internal source and the spare code drive nothing.
    always_comb
    begin
        div_nxt  = ~div_r;
        pen_nxt  = uses_pll;
        mult_nxt = 3'(PLK_MULT - 1);
        fb_nxt   = 1'b1;
        pin_nxt  = '0;
        unique case (mode)
            PLK_MODE_EC:
            begin
                fb_nxt = 1'b0;
                if (osc_pin_clkout_select)
                begin
                    pin_nxt.out = div_nxt;
                    pin_nxt.oe  = 1'b1;
                end
                else
                begin
                    pin_nxt.out = gpio_out;
                    pin_nxt.oe  = gpio_oe;
                end
            end
            PLK_MODE_EC_PLL:
            begin
                fb_nxt = 1'b0;
                if (osc_pin_clkout_select)
                begin
                    pin_nxt.out = div_nxt;
                    pin_nxt.oe  = 1'b1;
                end
                else
                begin
                    pin_nxt.out = gpio_out;
                    pin_nxt.oe  = gpio_oe;
                end
            end
            PLK_MODE_XT, PLK_MODE_XT_PLL, PLK_MODE_HS:
            begin
                // Pin carries crystal feedback, never driven as a port
                fb_nxt  = 1'b1;
                pin_nxt = '0;
            end
            PLK_MODE_FRC, PLK_MODE_FRC_PLL:
            begin
                // Internal source: pin idle, feedback left as after reset
                fb_nxt  = 1'b1;
                pin_nxt = '0;
            end
            PLK_MODE_OTHER:
            begin
                // Spare code behaves as a plain non-loop source
                fb_nxt  = 1'b1;
                pin_nxt = '0;
            end
        endcase
    end

    // Pin, feedback and multiplier registers.
    // Outputs come from here directly, so the pin never glitches on a
    // mode change; everything follows the mode one edge later.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            div_r  <= 1'b0;
            pin_r  <= '0;
            fb_r   <= 1'b1;
            pen_r  <= 1'b0;
            mult_r <= 3'h0;
        end
        else
        begin
            div_r  <= div_nxt;
            pin_r  <= pin_nxt;
            fb_r   <= fb_nxt;
            pen_r  <= pen_nxt;
            mult_r <= mult_nxt;
        end
    end

    // Ready timer and lock status next values.
    // The count runs on synchronised reference edges, not on the system
    // clock, so the settle time scales with the loop's own input.
    // Lock is purely timer based: once set it only falls on a source
    // change or a non-loop source, never on a real loss of lock.
    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        lock_nxt = lock_r;
        src_nxt  = mode;
        if (!uses_pll)
        begin
            st_nxt   = PLK_ST_IDLE;
            cnt_nxt  = PLK_CNT_ZERO;
            lock_nxt = 1'b0;
        end
        else if (src_changed)
        begin
            // A new source, even another loop mode, restarts the count
            st_nxt   = PLK_ST_SETTLE;
            cnt_nxt  = PLK_CNT_ZERO;
            lock_nxt = 1'b0;
        end
        else if (st_r == PLK_ST_IDLE)
        begin
            // Idle in an unchanged loop mode; not reached, as src_r resets to a non-loop mode
            st_nxt   = PLK_ST_SETTLE;
            cnt_nxt  = PLK_CNT_ZERO;
            lock_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                PLK_ST_SETTLE:
                begin
                    if (ref_edge)
                    begin
                        if (cnt_r == PLK_SETTLE_CYCLES - PLK_CNT_ONE)
                        begin
                            st_nxt   = PLK_ST_LOCKED;
                            lock_nxt = 1'b1;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r + PLK_CNT_ONE;
                        end
                    end
                end
                PLK_ST_LOCKED:
                begin
                    lock_nxt = 1'b1;
                end
                default:
                begin
                    st_nxt = PLK_ST_IDLE;
                end
            endcase
        end
    end

    // Control register: lock bit overrides any software value.
    // The status bit takes the lock next value, so the register and the
    // lock output change on the same edge and a write in the cycle of a
    // set or clear cannot hide it.
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (ctrl_we)
        begin
            ctrl_nxt = ctrl_wdata;
        end
        ctrl_nxt[PLK_LOCK_BIT] = lock_nxt;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r   <= PLK_ST_IDLE;
            cnt_r  <= PLK_CNT_ZERO;
            lock_r <= 1'b0;
            src_r  <= PLK_MODE_EC;
        end
        else
        begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            lock_r <= lock_nxt;
            src_r  <= src_nxt;
        end
    end

    // Control register storage; reset clears the lock bit with the rest
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_r <= PLK_CTRL_RST;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Outputs straight from flip-flops.
    // Ready and lock share one register: the loop output is declared usable
    // exactly when the settle count has run out, no earlier.
    assign oscillator_control_reg = ctrl_r;
    assign osc_output_pin         = pin_r;
    assign feedback_en            = fb_r;
    assign pll_enable             = pen_r;
    assign pll_mult_m1            = mult_r;
    assign pll_ready              = lock_r;
    assign pll_lock               = lock_r;

endmodule

`default_nettype wire

// ==== sim/plk_ref_osc.sv ====
`timescale 1ns/1ps
`default_nettype none
// External clock driver on the input pin, prompt or slow
module plk_ref_osc (
    input  wire logic run,      // Oscillates while high
    input  wire logic fast,     // Short or long period
    output var logic  ref_tick  // Level on the input pin
);
    // Free-running source; parks low when stopped to mimic a lost input
    initial
    begin
        ref_tick = 1'b0;
        forever
        begin
            #(fast ? 75 : 310);
            ref_tick = run & ~ref_tick;
        end
    end
endmodule
`default_nettype wire

// ==== sim/plk_clock_path_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module plk_clock_path_assertions
    import plk_pkg::*;
(
    input wire logic                  core_clk,              // Clock
    input wire logic                  rst,                   // Reset
    input wire logic [2:0]            osc_mode,              // Mode
    input wire logic                  osc_pin_clkout_select, // Clock-out bit
    input wire logic                  gpio_out,              // Port value
    input wire logic                  gpio_oe,               // Port enable
    input wire logic [PLK_CTRL_W-1:0] oscillator_control_reg, // Control
    input wire plk_pin_s              osc_output_pin,        // Pin
    input wire logic                  feedback_en,           // Feedback
    input wire logic                  pll_ready,             // Ready
    input wire logic                  pll_lock               // Lock
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Clock-out held selected in plain external mode
    sequence clkout_held;
        (osc_mode == 3'h0 && osc_pin_clkout_select) [*2];
    endsequence
    // Pin, feedback and lock relations
    clkout_half_a: assert property (clkout_held |=> osc_output_pin.oe &&
        osc_output_pin.out != $past(osc_output_pin.out)) else $error("pin not toggling");
    pin_gpio_a: assert property (osc_mode == 3'h0 && !osc_pin_clkout_select |=>
        osc_output_pin == {$past(gpio_out), $past(gpio_oe)}) else $error("pin not port");
    feedback_off_a: assert property (
        1'b1 |=> feedback_en == ($past(osc_mode) > 3'h1)) else $error("feedback wrong");
    ready_lock_a: assert property (pll_ready == pll_lock) else $error("ready differs");
    lock_nopll_a: assert property (!(osc_mode inside {3'h1, 3'h3, 3'h6}) |=>
        !pll_lock) else $error("lock without loop");
    switch_clear_a: assert property ($changed(osc_mode) |=> !pll_lock)
        else $error("lock kept on switch");
    lock_hold_a: assert property (pll_lock && $stable(osc_mode) |=> pll_lock)
        else $error("lock dropped");
    lock_bit_a: assert property (oscillator_control_reg[5] == pll_lock)
        else $error("status bit wrong");
endmodule
bind plk_clock_path plk_clock_path_assertions i_plk_clock_path_assertions (.*);
`default_nettype wire

// ==== sim/plk_clock_path_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module plk_clock_path_tb import plk_pkg::*;;
    logic                  core_clk, rst, sel, g_out, g_oe, we, run, fast, ref_tick;
    logic                  fb, pen, rdy, lock, a;
    logic [2:0]            mode, mult;
    logic [PLK_CTRL_W-1:0] wd, ctrl;
    plk_pin_s              pin;
    int                    n_fail, num_checks, cyc;
    plk_clock_path i_plk_clock_path (.core_clk(core_clk), .rst(rst), .osc_mode(mode),
        .osc_pin_clkout_select(sel), .ref_tick(ref_tick), .gpio_out(g_out),
        .gpio_oe(g_oe), .ctrl_wdata(wd), .ctrl_we(we), .oscillator_control_reg(ctrl),
        .osc_output_pin(pin), .feedback_en(fb), .pll_enable(pen), .pll_mult_m1(mult),
        .pll_ready(rdy), .pll_lock(lock));
    plk_ref_osc i_plk_ref_osc (.run(run), .fast(fast), .ref_tick(ref_tick));
    // Clock and hang guard
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            test_done;
        end
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc_n(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    // Every mode code with the loop source stopped
    task t_modes;
        logic ec;
        logic pl;
        for (int m = 0; m < 8; m++)
        begin
            mode = 3'(m);
            ec = m < 2;
            pl = m == 1 || m == 3 || m == 6;
            cyc_n(2);
            check({pin, fb, pen, mult, lock}, {ec, ec, !ec, pl, 3'h3, 1'b0});
        end
    endtask
    // Half-rate clock on the pin in both external modes
    task t_clkout;
        sel = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            mode = 3'(m);
            cyc_n(2);
            a = pin.out;
            cyc_n(1);
            check({6'h0, pin}, {6'h0, !a, 1'b1});
        end
        sel = 1'b0;
    endtask
    // Wait for lock and judge the delay and status bit
    task wait_lock(input int lo);
        int k;
        k = 0;
        while (lock !== 1'b1 && k < 9000)
        begin
            cyc_n(1);
            k++;
        end
        check({7'h0, k >= lo && k < 9000}, 8'h01);
        check({7'h0, ctrl[5]}, 8'h01);
    endtask
    // Lock, lost input, write, restart and release
    task t_lock;
        run = 1'b1;
        mode = 3'h1;
        wait_lock(1500);
        run = 1'b0;
        wd = 16'hA5C3;
        we = 1'b1;
        cyc_n(1);
        we = 1'b0;
        cyc_n(50);
        check(ctrl[15:8], 8'hA5);
        check(ctrl[7:0], 8'hE3);
        run = 1'b1;
        fast = 1'b0;
        mode = 3'h3;
        cyc_n(3000);
        check({7'h0, lock}, 8'h00);
        mode = 3'h6;
        wait_lock(6300);
        mode = 3'h2;
        wd = 16'h0020;
        we = 1'b1;
        cyc_n(1);
        we = 1'b0;
        cyc_n(2);
        check(ctrl[7:0], 8'h00);
    endtask
    initial
    begin
        {rst, run, fast} = 3'b101;
        {sel, g_out, g_oe, we, mode, wd} = '0;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        cyc_n(10);
        check({pin, fb, pen, mult, lock}, 8'h20);
        check({7'h0, ctrl[5]}, 8'h00);
        rst = 1'b0;
        {g_out, g_oe} = 2'b11;
        t_modes;
        t_clkout;
        t_lock;
        test_done;
    end
endmodule
`default_nettype wire
